/* pcr_pkg.sv */
// package of offsets, fields, reset values and carrier types for the pcs regs
package pcr_pkg;

   // ****************************************************************
   // word offsets
   // ****************************************************************
   localparam logic [4:0] OFS_CONTROL     = 5'h00;
   localparam logic [4:0] OFS_EXT_STATUS  = 5'h0f;
   localparam logic [4:0] OFS_SCRATCH     = 5'h10;
   localparam logic [4:0] OFS_VERSION     = 5'h11;
   localparam logic [4:0] OFS_TIMER_LOW   = 5'h12;
   localparam logic [4:0] OFS_TIMER_HIGH  = 5'h13;
   localparam logic [4:0] OFS_IFACE_SEL   = 5'h14;
   localparam logic [4:0] OFS_RSVD_FIRST  = 5'h17;
   localparam logic [4:0] OFS_RSVD_LAST   = 5'h1f;
   // byte address = word offset times four
   localparam int         ADDR_LSB        = 2;

   // ****************************************************************
   // control word fields and interface select bit
   // ****************************************************************
   localparam int BIT_UNIDIR      = 5;
   localparam int BIT_RATE_LOW    = 6;
   localparam int BIT_COL_TEST    = 7;
   localparam int BIT_DUPLEX      = 8;
   localparam int BIT_AN_RESTART  = 9;
   localparam int BIT_ISOLATE     = 10;
   localparam int BIT_POWERDOWN   = 11;
   localparam int BIT_AN_ENABLE   = 12;
   localparam int BIT_RATE_HIGH   = 13;
   localparam int BIT_LOOPBACK    = 14;
   localparam int BIT_SOFT_RESET  = 15;
   localparam int BIT_IFACE_SGMII = 0;

   // ****************************************************************
   // reset values and constants
   // ****************************************************************
   localparam logic [15:0] RST_CONTROL    = 16'h1140;
   localparam logic [15:0] RST_SCRATCH    = 16'h0000;
   localparam logic [15:0] RST_TIMER_LOW  = 16'h8968;
   localparam logic [4:0]  RST_TIMER_HIGH = 5'h09;
   localparam logic [15:0] RST_IFACE_SEL  = 16'h0000;
   // arbitrary neutral revision value
   localparam logic [15:0] CORE_VERSION   = 16'h0100;
   localparam int          TIMER_WIDTH    = 21;
   // timer unit and range, figures as printed
   localparam int          TIMER_STEP_NS  = 8;
   localparam int          TIMER_MAX_MS   = 16;
   // soft reset pulse length in ref_clk cycles
   localparam logic [1:0]  SRST_CYCLES    = 2'h1;

   // ****************************************************************
   // carrier types
   // ****************************************************************
   typedef struct packed {
      logic        an_enable;
      logic        an_restart;
      logic        unidir_tx;
      logic        isolate;
      logic        powerdown;
      logic        loopback;
      logic        soft_reset;
      logic        sgmii_mode;
      logic [20:0] link_timer;
   } pcr_ctrl_s;

   typedef struct packed {
      logic        we;
      logic [4:0]  word;
      logic [15:0] data;
   } pcr_wr_s;

endpackage : pcr_pkg

/* pcr_wb_slave.sv */
// classic wishbone slave front end producing one-cycle word write strobes
`timescale 1ns/1ns
module pcr_wb_slave (
   // clock and reset
   input  wire logic                ref_clk,
   input  wire logic                reset,
   // wishbone
   input  wire logic                wb_cyc_i,
   input  wire logic                wb_stb_i,
   input  wire logic                wb_we_i,
   input  wire logic [7:0]          wb_adr_i,
   input  wire logic [3:0]          wb_sel_i,
   input  wire logic [31:0]         wb_dat_i,
   output logic                     wb_ack_o,
   // register side
   output pcr_pkg::pcr_wr_s         wr,
   output logic [4:0]               rd_word
);

   // ****************************************************************
   // decode
   // ****************************************************************
   // new request only while no ack is pending, so one ack per cycle pair
   wire logic req_new = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   // low half lanes carry the 16-bit word
   wire logic lanes_ok = wb_sel_i[0] & wb_sel_i[1];
   wire logic [4:0] word_ix = wb_adr_i[pcr_pkg::ADDR_LSB +: 5];

   assign rd_word = word_ix;

   // ack one cycle after the request; write strobe on the same edge
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wb_ack_o <= 1'b0;
         wr       <= '0;
      end else begin
         wb_ack_o <= req_new;
         wr.we    <= req_new & wb_we_i & lanes_ok;
         wr.word  <= word_ix;
         wr.data  <= wb_dat_i[15:0];
      end
   end

endmodule : pcr_wb_slave

/* pcr_soft_reset.sv */
// self clearing soft reset pulse stretcher
`timescale 1ns/1ns
module pcr_soft_reset (
   // clock and reset
   input  wire logic  ref_clk,
   input  wire logic  reset,
   // trigger and pulse
   input  wire logic  trigger,
   output logic       pulse
);

   logic [1:0] count;

   // ****************************************************************
   // pulse counter
   // ****************************************************************
   // retrigger restarts the count so the pulse never cuts short
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         count <= 2'h0;
         pulse <= 1'b0;
      end else if (trigger) begin
         count <= pcr_pkg::SRST_CYCLES - 2'h1;
         pulse <= 1'b1;
      end else if (count != 2'h0) begin
         count <= count - 2'h1;
      end else begin
         pulse <= 1'b0;
      end
   end

endmodule : pcr_soft_reset

/* pcr_regs.sv */
// pcs control and configuration register bank top
//
// Contract
// - extended status at 0x0f reads zero only
// - scratch 0x10 read write, resets zero
// - revision at 0x11 read only constant
// - link timer is 21 bit count
// - timer resets to 0x8968 and 0x0009
// - timer low at 0x12, bit0 zero
// - timer high at 0x13, five bits
// - interface select at 0x14, resets zero
// - unidirectional ignored while autoneg enabled
// - unidirectional lets transmit without link
// - rate bits read fixed gigabit code
// - collision test bit reads zero
// - duplex bit reads one
// - restart bit write restarts negotiation
// - isolate bit isolates from mac
// - powerdown bit drives powerdown output
// - autoneg enable bit resets to one
// - loopback bit, ignored with reduced interface
// - soft reset bit pulses, self clears
// - control word at 0x00 resets 0x1140
`timescale 1ns/1ns
module pcr_regs (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        reset,
   // wishbone
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // link state from the sublayer
   input  wire logic        link_ok,
   input  wire logic        reduced_ten_bit_iface,
   // control outputs
   output logic             an_enable,
   output logic             an_restart,
   output logic             tx_permit,
   output logic             isolate,
   output logic             powerdown,
   output logic             loopback,
   output logic             soft_reset,
   output logic             sgmii_mode,
   output logic [20:0]      link_timer
);

   // ****************************************************************
   // storage
   // ****************************************************************
   pcr_pkg::pcr_wr_s wr;
   logic [4:0]       rd_word;
   logic             unidir;
   logic             an_en_q;
   logic             isolate_q;
   logic             powerdown_q;
   logic             loopback_q;
   logic [15:0]      scratch_word;
   logic [15:1]      timer_low;
   logic [4:0]       timer_high;
   logic [15:0]      interface_select;
   logic             srst_pulse;

   pcr_wb_slave u_bus (
      .ref_clk  (ref_clk),
      .reset    (reset),
      .wb_cyc_i (wb_cyc_i),
      .wb_stb_i (wb_stb_i),
      .wb_we_i  (wb_we_i),
      .wb_adr_i (wb_adr_i),
      .wb_sel_i (wb_sel_i),
      .wb_dat_i (wb_dat_i),
      .wb_ack_o (),
      .wr       (wr),
      .rd_word  (rd_word)
   );

   // ****************************************************************
   // write decode
   // ****************************************************************
   // read only and reserved words have no strobe, so writes vanish
   // writes to others dropped
   wire logic wr_ctrl  = wr.we & (wr.word == pcr_pkg::OFS_CONTROL);
   wire logic wr_scr   = wr.we & (wr.word == pcr_pkg::OFS_SCRATCH);
   wire logic wr_tlow  = wr.we & (wr.word == pcr_pkg::OFS_TIMER_LOW);
   wire logic wr_thigh = wr.we & (wr.word == pcr_pkg::OFS_TIMER_HIGH);
   wire logic wr_ifs   = wr.we & (wr.word == pcr_pkg::OFS_IFACE_SEL);
   wire logic [15:0] wd = wr.data;

   wire logic restart_hit = wr_ctrl & wd[pcr_pkg::BIT_AN_RESTART];
   wire logic srst_hit = wr_ctrl & wd[pcr_pkg::BIT_SOFT_RESET];

   pcr_soft_reset u_srst (
      .ref_clk (ref_clk),
      .reset   (reset),
      .trigger (srst_hit),
      .pulse   (srst_pulse)
   );

   // ****************************************************************
   // control word fields
   // ****************************************************************
   // control reset value
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         unidir      <= pcr_pkg::RST_CONTROL[pcr_pkg::BIT_UNIDIR];
         an_en_q     <= pcr_pkg::RST_CONTROL[pcr_pkg::BIT_AN_ENABLE];
         isolate_q   <= pcr_pkg::RST_CONTROL[pcr_pkg::BIT_ISOLATE];
         powerdown_q <= pcr_pkg::RST_CONTROL[pcr_pkg::BIT_POWERDOWN];
         loopback_q  <= pcr_pkg::RST_CONTROL[pcr_pkg::BIT_LOOPBACK];
      end else if (wr_ctrl) begin
         unidir      <= wd[pcr_pkg::BIT_UNIDIR];
         an_en_q     <= wd[pcr_pkg::BIT_AN_ENABLE];
         isolate_q   <= wd[pcr_pkg::BIT_ISOLATE];
         powerdown_q <= wd[pcr_pkg::BIT_POWERDOWN];
         loopback_q  <= wd[pcr_pkg::BIT_LOOPBACK];
      end
   end

   // ****************************************************************
   // extended words
   // ****************************************************************
   // scratch store
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         scratch_word <= pcr_pkg::RST_SCRATCH;
      end else if (wr_scr) begin
         scratch_word <= wd;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         timer_low  <= pcr_pkg::RST_TIMER_LOW[15:1];
         timer_high <= pcr_pkg::RST_TIMER_HIGH;
      end else begin
         if (wr_tlow) begin
            timer_low <= wd[15:1];
         end
         if (wr_thigh) begin
            timer_high <= wd[4:0];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         interface_select <= pcr_pkg::RST_IFACE_SEL;
      end else if (wr_ifs) begin
         interface_select <= wd;
      end
   end

   // ****************************************************************
   // read mux
   // ****************************************************************
   // rate indication gigabit
   // duplex reads one
   // restart and reset bits read zero since they act as pulses
   wire logic [15:0] ctrl_rd = {
      1'b0,                 // soft reset, self clearing
      loopback_q,
      1'b0,                 // rate indication high
      an_en_q,
      powerdown_q,
      isolate_q,
      1'b0,                 // restart
      1'b1,                 // duplex
      1'b0,                 // collision test
      1'b1,                 // rate indication low
      unidir,
      5'h00};

   wire logic [20:0] timer_full = {timer_high, timer_low, 1'b0};

   logic [15:0] rd_mux;
   always_comb begin
      case (rd_word)
         pcr_pkg::OFS_CONTROL:    rd_mux = ctrl_rd;
         pcr_pkg::OFS_EXT_STATUS: rd_mux = 16'h0000;
         pcr_pkg::OFS_SCRATCH:    rd_mux = scratch_word;
         pcr_pkg::OFS_VERSION:    rd_mux = pcr_pkg::CORE_VERSION;
         pcr_pkg::OFS_TIMER_LOW:  rd_mux = {timer_low, 1'b0};
         pcr_pkg::OFS_TIMER_HIGH: rd_mux = {11'h000, timer_high};
         pcr_pkg::OFS_IFACE_SEL:  rd_mux = interface_select;
         default:                 rd_mux = 16'h0000;
      endcase
   end

   // ****************************************************************
   // bus answer
   // ****************************************************************
   // ack duplicated here so the output stays a local flip-flop
   wire logic req_new = wb_cyc_i & wb_stb_i & ~wb_ack_o;

   // read data sampled with the request, upper half always zero
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req_new;
         wb_dat_o <= {16'h0000, rd_mux};
      end
   end

   // ****************************************************************
   // control outputs
   // ****************************************************************
   // registered so each output leaves straight from a flip-flop
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         an_enable  <= 1'b0;
         an_restart <= 1'b0;
         tx_permit  <= 1'b0;
         isolate    <= 1'b0;
         powerdown  <= 1'b0;
         loopback   <= 1'b0;
         soft_reset <= 1'b0;
         sgmii_mode <= 1'b0;
         link_timer <= 21'h000000;
      end else begin
         an_enable  <= an_en_q;
         an_restart <= restart_hit;
         tx_permit  <= link_ok | (unidir & ~an_en_q);
         isolate    <= isolate_q;
         powerdown  <= powerdown_q;
         loopback   <= loopback_q & ~reduced_ten_bit_iface;
         soft_reset <= srst_pulse;
         sgmii_mode <= interface_select[pcr_pkg::BIT_IFACE_SGMII];
         link_timer <= timer_full;
      end
   end

endmodule : pcr_regs

/* pcr_regs_monitor.sv */
// concurrent checks on the pcs register bank ports
`timescale 1ns/1ns
module pcr_regs_monitor (
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        reset,
   // wishbone
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // sublayer side
   input wire logic        link_ok,
   input wire logic        reduced_ten_bit_iface,
   input wire logic        an_enable,
   input wire logic        an_restart,
   input wire logic        tx_permit,
   input wire logic        isolate,
   input wire logic        powerdown,
   input wire logic        loopback,
   input wire logic        soft_reset,
   input wire logic        sgmii_mode,
   input wire logic [20:0] link_timer
);
   // ****************************************************************
   // completed access decode
   // ****************************************************************
   // a write only lands with both low byte lanes enabled
   wire logic [4:0] ofs   = wb_adr_i[6:2];
   wire logic       wr_ok = wb_ack_o & wb_we_i & wb_sel_i[0] & wb_sel_i[1];
   wire logic       rd_ok = wb_ack_o & ~wb_we_i;
   wire logic       wr_c  = wr_ok & (ofs == pcr_pkg::OFS_CONTROL);

   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);

   // self clearing strobes last exactly one cycle
   sequence single_pulse(sig);
      sig ##1 !sig;
   endsequence

   ack_one_cycle_a: assert property (wb_cyc_i & wb_stb_i & ~wb_ack_o
      |=> wb_ack_o ##1 !wb_ack_o) else $error("ack timing wrong");
   zero_read_a: assert property (rd_ok && (ofs == pcr_pkg::OFS_EXT_STATUS
      || ofs >= pcr_pkg::OFS_RSVD_FIRST) |-> wb_dat_o == 32'h0)
      else $error("empty word not zero");
   ctrl_fixed_a: assert property (rd_ok && ofs == pcr_pkg::OFS_CONTROL
      |-> (wb_dat_o[15:0] & 16'ha3df) == 16'h0140)
      else $error("fixed control bits wrong");
   timer_bits_a: assert property (rd_ok |-> !(ofs == pcr_pkg::OFS_TIMER_LOW
      && wb_dat_o[0]) && !(ofs == pcr_pkg::OFS_TIMER_HIGH && |wb_dat_o[15:5]))
      else $error("timer unused bits set");
   // fields land at the ack edge, the outputs follow one edge later
   ctrl_write_a: assert property (wr_c |-> ##2
      {powerdown, isolate, an_enable} == {$past(wb_dat_i[11], 2),
      $past(wb_dat_i[10], 2), $past(wb_dat_i[12], 2)})
      else $error("control outputs wrong");
   restart_pulse_a: assert property (wr_c && wb_dat_i[9]
      |=> single_pulse(an_restart)) else $error("restart pulse wrong");
   // soft reset passes the pulse stretcher, so it trails restart by one
   soft_pulse_a: assert property (wr_c && wb_dat_i[15]
      |=> ##1 single_pulse(soft_reset)) else $error("soft reset pulse wrong");
   tx_gate_a: assert property (!$past(reset) && $past(an_enable)
      && an_enable && !$past(link_ok) |-> !tx_permit)
      else $error("unidirectional not ignored");
   link_permit_a: assert property (!$past(reset) && $past(link_ok)
      |-> tx_permit) else $error("no permit with link");
   loop_block_a: assert property (!$past(reset)
      && $past(reduced_ten_bit_iface) |-> !loopback)
      else $error("loopback not blocked");
endmodule : pcr_regs_monitor

/* pcr_host_model.sv */
// host software model issuing classic wishbone single cycles
`timescale 1ns/1ns
module pcr_host_model (
   // clock
   input  wire logic        ref_clk,
   // wishbone towards the bank
   output logic             wb_cyc_i,
   output logic             wb_stb_i,
   output logic             wb_we_i,
   output logic [7:0]       wb_adr_i,
   output logic [3:0]       wb_sel_i,
   output logic [31:0]      wb_dat_i,
   input  wire logic [31:0] wb_dat_o,
   input  wire logic        wb_ack_o
);
   // idle bus from time zero
   initial begin
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i  = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0;
   end

   // one cycle; ok stays low if no ack arrives within the bound
   task automatic xfer(input logic w, input logic [4:0] ofs,
         input logic [15:0] wd, input logic [3:0] s,
         output logic [15:0] rd, output logic ok);
      logic [9:0] badr;
      int         n;
      // rebase by 0x80, words to bytes
      badr = (10'h080 + {5'h00, ofs}) << 2;
      rd = 16'h0000;
      ok = 1'b0;
      n = 0;
      @(posedge ref_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= badr[7:0];
      wb_sel_i <= s;
      wb_dat_i <= {16'h0000, wd};
      // ack and read data are taken at the rising edge that sees ack high
      while (!ok && n < 16) begin
         @(posedge ref_clk);
         n++;
         if (wb_ack_o === 1'b1) begin
            ok = 1'b1;
            rd = wb_dat_o[15:0];
         end
      end
      // released address and data lines show the inverse so stale values never match
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_adr_i <= ~wb_adr_i;
      wb_dat_i <= ~wb_dat_i;
   endtask : xfer
endmodule : pcr_host_model

/* pcr_regs_bench.sv */
// self checking bench for the pcs register bank
`timescale 1ns/1ns
module pcr_regs_bench;
   logic        ref_clk = 1'b0;
   logic        reset = 1'b1;
   logic        link_ok = 1'b0;
   logic        reduced_ten_bit_iface = 1'b0;
   logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic        an_enable, an_restart, tx_permit, isolate, powerdown;
   logic        loopback, soft_reset, sgmii_mode;
   logic [20:0] link_timer;
   int          error_cnt = 0;
   int          check_count = 0;

   always #50 ref_clk = ~ref_clk;

   pcr_regs dut (.ref_clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .link_ok,
      .reduced_ten_bit_iface, .an_enable, .an_restart, .tx_permit, .isolate,
      .powerdown, .loopback, .soft_reset, .sgmii_mode, .link_timer);
   pcr_host_model host (.ref_clk, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);

   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic complete_run();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run

   task automatic compare(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : compare

   task automatic acc(input logic w, input logic [4:0] o,
         input logic [15:0] wd, input logic [3:0] s, output logic [15:0] d);
      logic ok;
      host.xfer(w, o, wd, s, d, ok);
      if (!ok) begin
         error_cnt++;
         complete_run();
      end
   endtask : acc

   task automatic wr(input logic [4:0] o, input logic [15:0] wd);
      logic [15:0] d;
      acc(1'b1, o, wd, 4'hf, d);
   endtask : wr

   task automatic rd_chk(input string what, input logic [4:0] o,
         input logic [15:0] exp);
      logic [15:0] d;
      acc(1'b0, o, 16'h0000, 4'hf, d);
      compare(what, {16'h0000, exp}, {16'h0000, d});
   endtask : rd_chk

   // outputs trail a write or an input change by up to two edges
   task automatic settle();
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask : settle

   task automatic reset_dut();
      reset <= 1'b1;
      repeat (12) @(posedge ref_clk);
      reset <= 1'b0;
      settle();
   endtask : reset_dut

   // counts strobe cycles over the few cycles after a write
   task automatic pulses(input logic [15:0] v, output logic [3:0] nr,
         output logic [3:0] ns);
      wr(pcr_pkg::OFS_CONTROL, v);
      nr = 4'h0;
      ns = 4'h0;
      repeat (4) begin
         @(negedge ref_clk);
         nr += {3'h0, an_restart === 1'b1};
         ns += {3'h0, soft_reset === 1'b1};
      end
   endtask : pulses

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_reset_values();
      compare("timer out", 32'h00098968, {11'h0, link_timer});
      compare("an_enable", 32'h1, {31'h0, an_enable});
      rd_chk("control", pcr_pkg::OFS_CONTROL, 16'h1140);
      rd_chk("scratch", pcr_pkg::OFS_SCRATCH, 16'h0000);
      rd_chk("timer low", pcr_pkg::OFS_TIMER_LOW, 16'h8968);
      rd_chk("timer high", pcr_pkg::OFS_TIMER_HIGH, 16'h0009);
      rd_chk("iface", pcr_pkg::OFS_IFACE_SEL, 16'h0000);
   endtask : t_reset_values

   task automatic t_words();
      logic [15:0] d;
      wr(pcr_pkg::OFS_SCRATCH, 16'ha5c3);
      acc(1'b1, pcr_pkg::OFS_SCRATCH, 16'h0f0f, 4'h1, d);
      rd_chk("scratch", pcr_pkg::OFS_SCRATCH, 16'ha5c3);
      wr(pcr_pkg::OFS_VERSION, 16'hffff);
      rd_chk("version", pcr_pkg::OFS_VERSION, pcr_pkg::CORE_VERSION);
      wr(pcr_pkg::OFS_EXT_STATUS, 16'hffff);
      rd_chk("ext status", pcr_pkg::OFS_EXT_STATUS, 16'h0000);
      for (int o = 'h17; o <= 'h1f; o++) begin
         wr(5'(o), 16'hffff);
         rd_chk("reserved", 5'(o), 16'h0000);
      end
      wr(pcr_pkg::OFS_IFACE_SEL, 16'hbeef);
      rd_chk("iface", pcr_pkg::OFS_IFACE_SEL, 16'hbeef);
      settle();
      compare("sgmii", 32'h1, {31'h0, sgmii_mode});
      wr(pcr_pkg::OFS_IFACE_SEL, 16'h0000);
      settle();
      compare("sgmii", 32'h0, {31'h0, sgmii_mode});
   endtask : t_words

   task automatic t_timer();
      wr(pcr_pkg::OFS_TIMER_LOW, 16'hffff);
      rd_chk("timer low", pcr_pkg::OFS_TIMER_LOW, 16'hfffe);
      wr(pcr_pkg::OFS_TIMER_HIGH, 16'hffff);
      rd_chk("timer high", pcr_pkg::OFS_TIMER_HIGH, 16'h001f);
      settle();
      compare("timer out", 32'h001ffffe, {11'h0, link_timer});
      wr(pcr_pkg::OFS_TIMER_LOW, 16'h0000);
      wr(pcr_pkg::OFS_TIMER_HIGH, 16'h0000);
      settle();
      compare("timer out", 32'h0, {11'h0, link_timer});
   endtask : t_timer

   task automatic t_control();
      logic [3:0] nr;
      logic [3:0] ns;
      wr(pcr_pkg::OFS_CONTROL, 16'h6ce0);
      rd_chk("control", pcr_pkg::OFS_CONTROL, 16'h4d60);
      settle();
      compare("outs", 32'h1f, {27'h0, isolate, powerdown, loopback,
         tx_permit, ~an_enable});
      @(posedge ref_clk);
      reduced_ten_bit_iface <= 1'b1;
      settle();
      compare("loopback", 32'h0, {31'h0, loopback});
      @(posedge ref_clk);
      reduced_ten_bit_iface <= 1'b0;
      wr(pcr_pkg::OFS_CONTROL, 16'h1020);
      settle();
      compare("tx_permit", 32'h0, {31'h0, tx_permit});
      @(posedge ref_clk);
      link_ok <= 1'b1;
      settle();
      compare("tx_permit", 32'h1, {31'h0, tx_permit});
      pulses(16'h1200, nr, ns);
      compare("restarts", 32'h1, {28'h0, nr});
      compare("soft resets", 32'h0, {28'h0, ns});
      rd_chk("control", pcr_pkg::OFS_CONTROL, 16'h1140);
      pulses(16'h9140, nr, ns);
      compare("restarts", 32'h0, {28'h0, nr});
      compare("soft resets", 32'h1, {28'h0, ns});
   endtask : t_control

   // a second reset in mid run brings back the defaults
   task automatic t_rerun();
      wr(pcr_pkg::OFS_SCRATCH, 16'h1234);
      @(posedge ref_clk);
      link_ok <= 1'b0;
      reset_dut();
      t_reset_values();
   endtask : t_rerun

   initial begin
      reset_dut();
      t_reset_values();
      t_words();
      t_timer();
      t_control();
      t_rerun();
      complete_run();
   end

   // watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge ref_clk);
      error_cnt++;
      complete_run();
   end
endmodule : pcr_regs_bench

bind pcr_regs pcr_regs_monitor mon (.ref_clk, .reset, .wb_cyc_i, .wb_stb_i,
   .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .link_ok,
   .reduced_ten_bit_iface, .an_enable, .an_restart, .tx_permit, .isolate,
   .powerdown, .loopback, .soft_reset, .sgmii_mode, .link_timer);
